// ==== src/swdm_cfg.svh ====
`ifndef SWDM_CFG_SVH
`define SWDM_CFG_SVH
// ****************************************
// Special-register addresses
// ****************************************
`define SWDM_ADDR_STATUS    8'hd0
`define SWDM_ADDR_STACK     8'h81
`define SWDM_ADDR_PTR_LOW   8'h82
`define SWDM_ADDR_PTR_HIGH  8'h83
`define SWDM_ADDR_PAGE      8'haa
// ****************************************
// Status word field positions
// ****************************************
`define SWDM_BIT_CARRY      3'd7
`define SWDM_BIT_HALF       3'd6
`define SWDM_BIT_USER0      3'd5
`define SWDM_BIT_BANK_HI    3'd4
`define SWDM_BIT_BANK_LO    3'd3
`define SWDM_BIT_OVF        3'd2
`define SWDM_BIT_USER1      3'd1
`define SWDM_BIT_PARITY     3'd0
// ****************************************
// Reset values and map limits
// ****************************************
`define SWDM_RST_STATUS     8'h00
`define SWDM_RST_STACK      8'h07
`define SWDM_RST_PTR        8'h00
`define SWDM_RST_PAGE       4'h0
`define SWDM_LOWER_TOP      8'h7f
`define SWDM_BIT_BASE       8'h20
`define SWDM_FLASH_TOP_BIG  16'hfbff
`define SWDM_FLASH_TOP_SML  16'h7fff
`define SWDM_MUL_LIMIT      16'h00ff
`endif

// ==== src/swdm_pkg.sv ====
package swdm_pkg;
  // ****************************************
  // Arithmetic operation codes
  // ****************************************
  typedef enum logic [2:0] {
    SWDM_ALU_NONE,
    SWDM_ALU_ADD,
    SWDM_ALU_ADDC,
    SWDM_ALU_SUBB,
    SWDM_ALU_MUL,
    SWDM_ALU_DIV,
    SWDM_ALU_OTHER
  } swdm_alu_op_t;

  // Data-memory access kinds
  typedef enum logic [2:0] {
    SWDM_ACC_NONE,
    SWDM_ACC_DIRECT,
    SWDM_ACC_INDIRECT,
    SWDM_ACC_BANKREG,
    SWDM_ACC_BIT,
    SWDM_ACC_PUSH,
    SWDM_ACC_POP
  } swdm_acc_kind_t;

  // Program/external space kinds
  typedef enum logic [1:0] {
    SWDM_PRG_NONE,
    SWDM_PRG_CODE_READ,
    SWDM_PRG_EXT_PTR16,
    SWDM_PRG_EXT_PAGED
  } swdm_prg_kind_t;

  // Target of a data-memory access
  typedef enum logic [2:0] {
    SWDM_TGT_NONE,
    SWDM_TGT_LOWER_RAM,
    SWDM_TGT_UPPER_RAM,
    SWDM_TGT_SPECIAL,
    SWDM_TGT_FLASH,
    SWDM_TGT_ONCHIP_EXT_RAM,
    SWDM_TGT_RESERVED
  } swdm_target_t;

  // Arithmetic request (op and operands) from the datapath
  typedef struct packed {
    logic         valid;
    swdm_alu_op_t op;
    logic [7:0]   opa;
    logic [7:0]   opb;
  } swdm_alu_req_t;

  // Data-memory access request
  typedef struct packed {
    logic           valid;
    swdm_acc_kind_t kind;
    logic [7:0]     addr;
    logic [2:0]     reg_num;
  } swdm_mem_req_t;

  // Resolved data-memory address
  typedef struct packed {
    swdm_target_t target;
    logic [7:0]   byte_addr;
    logic [2:0]   bit_pos;
    logic         is_bit;
  } swdm_mem_map_t;

  // Program or external request
  typedef struct packed {
    logic           valid;
    swdm_prg_kind_t kind;
    logic           write;
    logic [15:0]    addr;
    logic [7:0]     index_val;
  } swdm_prg_req_t;

  // Resolved program/external address
  typedef struct packed {
    swdm_target_t target;
    logic [15:0]  addr;
    logic         lock_byte;
  } swdm_prg_map_t;

  // Special-register write/read port
  typedef struct packed {
    logic       wr;
    logic       bit_wr;
    logic [7:0] addr;
    logic [2:0] bit_pos;
    logic [7:0] wdata;
  } swdm_sfr_req_t;

  // All held state
  typedef struct packed {
    logic [7:0]    status;
    logic [7:0]    stack;
    logic [7:0]    ptr_low;
    logic [7:0]    ptr_high;
    logic [3:0]    page;
    swdm_mem_map_t mem_out;
    swdm_prg_map_t prg_out;
    logic [7:0]    sfr_rdata;
  } swdm_state_t;
endpackage

// ==== src/swdm_core.sv ====
// Operation
// RULE1: carry bit 7 from add carry/sub borrow
// RULE2: half-carry bit 6 from nibble carry/borrow
// RULE3: user flags bits 5,1 software only
// RULE4: bank select bits 4:3 choose bank
// RULE5: overflow on signed, mul>255, divide zero
// RULE6: overflow cleared otherwise by those ops
// RULE7: parity bit 0 mirrors accumulator odd count
// RULE8: status word at 0xD0, byte/bit access
// RULE9: flash contiguous to variant top address
// RULE10: top flash is lock, above reserved
// RULE11: code reads flash, ext moves onchip_ext_ram/flash
// RULE12: 256 bytes internal, lower direct/indirect
// RULE13: above 0x7F direct special, indirect RAM
// RULE14: 0x00-0x1F four banks, active bank used
// RULE15: only registers 0,1 index indirectly
// RULE16: bit address maps onto 0x20-0x2F
// RULE17: bit versus byte from instruction type
// RULE18: push writes pointer+1 then increments
// RULE19: stack pointer resets to 0x07
// RULE20: stack anywhere in 256 byte RAM
// RULE21: 4096 onchip_ext_ram bytes via pointer or page
// RULE22: page high byte, upper nibble reads zero
// RULE23: 16-bit pointer from low/high registers
// RULE24: pop reads pointer then decrements
`timescale 1ns/10ps
`default_nettype none
`include "swdm_cfg.svh"

module swdm_core
#(
  parameter bit BIG_VARIANT = 1'b1
)
(
  input  wire logic                   i_sys_clk,
  input  wire logic                   i_rst,
  input  wire swdm_pkg::swdm_alu_req_t i_alu,
  input  wire logic [7:0]             i_accum,
  input  wire swdm_pkg::swdm_sfr_req_t i_sfr,
  input  wire logic                   i_flash_wr_en,
  input  wire swdm_pkg::swdm_mem_req_t i_mem,
  input  wire logic [7:0]             i_index_val,
  input  wire swdm_pkg::swdm_prg_req_t i_prg,
  output logic [7:0]                  o_status_word,
  output logic [7:0]                  o_stack_top_ptr,
  output logic [15:0]                 o_indirect_pointer16,
  output logic [7:0]                  o_onchip_ext_ram_page_reg,
  output logic [7:0]                  o_sfr_rdata,
  output swdm_pkg::swdm_mem_map_t     o_mem_map,
  output swdm_pkg::swdm_prg_map_t     o_prg_map
);

  // ****************************************
  // Helpers
  // ****************************************
  // Bank n starts at byte n*8, so the bank code simply
  // lands in address bits 4:3 above the register number.
  // Working-register byte address in the selected bank
  function automatic logic [7:0] bank_addr(input logic [1:0] bank, input logic [2:0] rnum);
    bank_addr = {3'b000, bank, rnum}; // [RULE4] [RULE14]
  endfunction

  // Odd number of ones gives one
  function automatic logic odd_ones(input logic [7:0] v);
    odd_ones = ^v; // [RULE7]
  endfunction

  // Upper half shares addresses with the special registers;
  // only the addressing mode tells the two spaces apart.
  // Route an 8-bit address by addressing mode
  function automatic swdm_pkg::swdm_target_t route(input logic [7:0] a, input logic indirect);
    if (a <= `SWDM_LOWER_TOP)
      route = swdm_pkg::SWDM_TGT_LOWER_RAM; // [RULE12]
    else if (indirect)
      route = swdm_pkg::SWDM_TGT_UPPER_RAM; // [RULE13]
    else
      route = swdm_pkg::SWDM_TGT_SPECIAL;   // [RULE13]
  endfunction

  // All held state in one struct, next value built below
  swdm_pkg::swdm_state_t s_q;
  swdm_pkg::swdm_state_t s_d;

  // Scratch arithmetic; all but flash_top and bank defaulted at the top of the process

  logic [8:0]  sum9;
  logic [4:0]  nib5;
  logic [15:0] prod;
  logic        cin;
  logic [15:0] flash_top;
  logic [1:0]  bank;
  logic [7:0]  wr_val;
  logic [7:0]  cur_val;

  // Variant picks the last flash byte, which is also the lock
  // Fixed at build time, so no run-time switch is offered
  assign flash_top = BIG_VARIANT ? `SWDM_FLASH_TOP_BIG : `SWDM_FLASH_TOP_SML; // [RULE9]
  // Active bank straight from the status word
  assign bank      = s_q.status[`SWDM_BIT_BANK_HI:`SWDM_BIT_BANK_LO];

  // ****************************************
  // Next-state logic
  // ****************************************
  always_comb
  begin
    s_d     = s_q;
    sum9    = 9'h000;
    nib5    = 5'h00;
    prod    = 16'h0000;
    cin     = 1'b0;
    wr_val  = 8'h00;
    cur_val = 8'h00;

    // Software write to a special register, byte or bit
    // A bit write merges into the current value, so the
    // other seven bits must be read back first.
    case (i_sfr.addr)
      `SWDM_ADDR_STATUS:   cur_val = s_q.status;
      `SWDM_ADDR_STACK:    cur_val = s_q.stack;
      `SWDM_ADDR_PTR_LOW:  cur_val = s_q.ptr_low;
      `SWDM_ADDR_PTR_HIGH: cur_val = s_q.ptr_high;
      `SWDM_ADDR_PAGE:     cur_val = {4'h0, s_q.page};
      default:             cur_val = 8'h00;
    endcase
    wr_val = cur_val;
    if (i_sfr.bit_wr)
      wr_val[i_sfr.bit_pos] = i_sfr.wdata[0]; // [RULE3] [RULE8]
    else
      wr_val = i_sfr.wdata;
    if (i_sfr.wr || i_sfr.bit_wr)
    begin
      case (i_sfr.addr)
        `SWDM_ADDR_STATUS:   s_d.status   = wr_val; // [RULE8]
        `SWDM_ADDR_STACK:    s_d.stack    = wr_val;
        `SWDM_ADDR_PTR_LOW:  s_d.ptr_low  = wr_val; // [RULE23]
        `SWDM_ADDR_PTR_HIGH: s_d.ptr_high = wr_val; // [RULE23]
        `SWDM_ADDR_PAGE:     s_d.page     = wr_val[3:0]; // [RULE22]
        default:             s_d.status   = s_d.status;
      endcase
    end

    // Arithmetic flags override a same-cycle software write
    // Hardware wins here: the datapath result is newer than
    // whatever software wrote in the same instruction slot.
    if (i_alu.valid)
    begin
      cin = s_q.status[`SWDM_BIT_CARRY];
      case (i_alu.op)
        // Plain add ignores the stored carry, chained add uses it
        swdm_pkg::SWDM_ALU_ADD, swdm_pkg::SWDM_ALU_ADDC:
        begin
          if (i_alu.op == swdm_pkg::SWDM_ALU_ADD)
            cin = 1'b0;
          sum9 = {1'b0, i_alu.opa} + {1'b0, i_alu.opb} + {8'h00, cin};
          nib5 = {1'b0, i_alu.opa[3:0]} + {1'b0, i_alu.opb[3:0]} + {4'h0, cin};
          s_d.status[`SWDM_BIT_CARRY] = sum9[8];  // [RULE1]
          s_d.status[`SWDM_BIT_HALF]  = nib5[4];  // [RULE2]
          s_d.status[`SWDM_BIT_OVF]   = (i_alu.opa[7] == i_alu.opb[7])
                                        && (sum9[7] != i_alu.opa[7]); // [RULE5] [RULE6]
        end
        swdm_pkg::SWDM_ALU_SUBB:
        begin
          // Borrow shows as bit 8 of the wrapped difference
          sum9 = {1'b0, i_alu.opa} - {1'b0, i_alu.opb} - {8'h00, cin};
          nib5 = {1'b0, i_alu.opa[3:0]} - {1'b0, i_alu.opb[3:0]} - {4'h0, cin};
          s_d.status[`SWDM_BIT_CARRY] = sum9[8];  // [RULE1]
          s_d.status[`SWDM_BIT_HALF]  = nib5[4];  // [RULE2]
          s_d.status[`SWDM_BIT_OVF]   = (i_alu.opa[7] != i_alu.opb[7])
                                        && (sum9[7] != i_alu.opa[7]); // [RULE5] [RULE6]
        end
        // Full 16-bit product, flagged when the high byte is used
        swdm_pkg::SWDM_ALU_MUL:
        begin
          prod = 16'(i_alu.opa) * 16'(i_alu.opb);
          s_d.status[`SWDM_BIT_CARRY] = 1'b0; // [RULE1]
          s_d.status[`SWDM_BIT_HALF]  = 1'b0; // [RULE2]
          s_d.status[`SWDM_BIT_OVF]   = prod > `SWDM_MUL_LIMIT; // [RULE5] [RULE6]
        end
        // Only the divisor matters for the flags
        swdm_pkg::SWDM_ALU_DIV:
        begin
          s_d.status[`SWDM_BIT_CARRY] = 1'b0; // [RULE1]
          s_d.status[`SWDM_BIT_HALF]  = 1'b0; // [RULE2]
          s_d.status[`SWDM_BIT_OVF]   = (i_alu.opb == 8'h00); // [RULE5] [RULE6]
        end
        swdm_pkg::SWDM_ALU_OTHER:
        begin
          // Other arithmetic clears the carries, overflow untouched
          s_d.status[`SWDM_BIT_CARRY] = 1'b0; // [RULE1]
          s_d.status[`SWDM_BIT_HALF]  = 1'b0; // [RULE2]
        end
        default:
          s_d.status = s_d.status;
      endcase
    end

    // Parity follows the accumulator; writes never stick
    // Recomputed every cycle, so it lags the accumulator by one
    s_d.status[`SWDM_BIT_PARITY] = odd_ones(i_accum); // [RULE7]

    // Data-memory address resolution
    // The map stands for one cycle only; idle cycles read as
    // no target so a stale address is never acted on twice.
    s_d.mem_out = '0;
    if (i_mem.valid)
    begin
      case (i_mem.kind)
        swdm_pkg::SWDM_ACC_DIRECT:
        begin
          s_d.mem_out.byte_addr = i_mem.addr;
          s_d.mem_out.target    = route(i_mem.addr, 1'b0); // [RULE13]
        end
        swdm_pkg::SWDM_ACC_INDIRECT:
        begin
          // Only bank registers 0 and 1 serve as index
          s_d.mem_out.byte_addr = i_index_val;
          s_d.mem_out.target    = i_mem.reg_num[2:1] == 2'b00 ?
                                  route(i_index_val, 1'b1) : swdm_pkg::SWDM_TGT_NONE; // [RULE15]
        end
        // Register operand always lands in the lower RAM
        swdm_pkg::SWDM_ACC_BANKREG:
        begin
          s_d.mem_out.byte_addr = bank_addr(bank, i_mem.reg_num); // [RULE14]
          s_d.mem_out.target    = swdm_pkg::SWDM_TGT_LOWER_RAM;
        end
        swdm_pkg::SWDM_ACC_BIT:
        begin
          // Bit vs byte decided by request kind alone
          s_d.mem_out.is_bit  = 1'b1; // [RULE17]
          s_d.mem_out.bit_pos = i_mem.addr[2:0];
          if (!i_mem.addr[7])
          begin
            s_d.mem_out.byte_addr = `SWDM_BIT_BASE + {4'h0, i_mem.addr[6:3]}; // [RULE16]
            s_d.mem_out.target    = swdm_pkg::SWDM_TGT_LOWER_RAM;
          end
          else
          begin
            // Upper bit addresses name a special register byte
            s_d.mem_out.byte_addr = {i_mem.addr[7:3], 3'b000};
            s_d.mem_out.target    = swdm_pkg::SWDM_TGT_SPECIAL;
          end
        end
        swdm_pkg::SWDM_ACC_PUSH:
        begin
          // Stack reaches all 256 bytes, upper half indirectly
          s_d.mem_out.byte_addr = s_q.stack + 8'h01; // [RULE18] [RULE20]
          s_d.mem_out.target    = route(s_q.stack + 8'h01, 1'b1);
          s_d.stack             = s_q.stack + 8'h01; // [RULE18]
        end
        // Pointer wraps through 0xff without a guard; the
        // user must keep the stack inside its chosen area.
        swdm_pkg::SWDM_ACC_POP:
        begin
          s_d.mem_out.byte_addr = s_q.stack; // [RULE24] [RULE20]
          s_d.mem_out.target    = route(s_q.stack, 1'b1);
          s_d.stack             = s_q.stack - 8'h01; // [RULE24]
        end
        default:
          s_d.mem_out.target = swdm_pkg::SWDM_TGT_NONE;
      endcase
    end

    // Program and external space routing
    // Code reads go to flash or reserved; only external-move writes can
    // be turned to flash, and only while the enable is high.
    s_d.prg_out = '0;
    if (i_prg.valid)
    begin
      case (i_prg.kind)
        swdm_pkg::SWDM_PRG_CODE_READ:
        begin
          s_d.prg_out.addr      = i_prg.addr;
          s_d.prg_out.lock_byte = i_prg.addr == flash_top; // [RULE10]
          s_d.prg_out.target    = i_prg.addr > flash_top ?
                                  swdm_pkg::SWDM_TGT_RESERVED : swdm_pkg::SWDM_TGT_FLASH; // [RULE9] [RULE10] [RULE11]
        end
        swdm_pkg::SWDM_PRG_EXT_PTR16, swdm_pkg::SWDM_PRG_EXT_PAGED:
        begin
          if (i_prg.kind == swdm_pkg::SWDM_PRG_EXT_PTR16)
            s_d.prg_out.addr = {s_q.ptr_high, s_q.ptr_low}; // [RULE21] [RULE23]
          else
            s_d.prg_out.addr = {4'h0, s_q.page, i_prg.index_val}; // [RULE21] [RULE22]
          // Writes go to flash only when redirected
          if (i_prg.write && i_flash_wr_en)
          begin
            s_d.prg_out.lock_byte = s_d.prg_out.addr == flash_top; // [RULE10]
            s_d.prg_out.target    = s_d.prg_out.addr > flash_top ?
                                    swdm_pkg::SWDM_TGT_RESERVED : swdm_pkg::SWDM_TGT_FLASH; // [RULE11]
          end
          else
            s_d.prg_out.target = swdm_pkg::SWDM_TGT_ONCHIP_EXT_RAM; // [RULE11]
        end
        default:
          s_d.prg_out.target = swdm_pkg::SWDM_TGT_NONE;
      endcase
    end

    // Registered read data for the addressed special register
    // One cycle of latency keeps the read path off the bus
    case (i_sfr.addr)
      `SWDM_ADDR_STATUS:   s_d.sfr_rdata = s_q.status; // [RULE8]
      `SWDM_ADDR_STACK:    s_d.sfr_rdata = s_q.stack;
      `SWDM_ADDR_PTR_LOW:  s_d.sfr_rdata = s_q.ptr_low;
      `SWDM_ADDR_PTR_HIGH: s_d.sfr_rdata = s_q.ptr_high;
      `SWDM_ADDR_PAGE:     s_d.sfr_rdata = {4'h0, s_q.page}; // [RULE22]
      default:             s_d.sfr_rdata = 8'h00;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  // Constants only in the reset branch
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      // Maps and read data clear; the stack points below bank one
      s_q          <= '0;
      s_q.status   <= `SWDM_RST_STATUS; // [RULE8]
      s_q.stack    <= `SWDM_RST_STACK;  // [RULE19]
      s_q.ptr_low  <= `SWDM_RST_PTR;    // [RULE23]
      s_q.ptr_high <= `SWDM_RST_PTR;
      s_q.page     <= `SWDM_RST_PAGE;
    end
    else
      s_q <= s_d;
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Every output comes straight from a flip-flop
  assign o_status_word        = s_q.status;
  assign o_stack_top_ptr      = s_q.stack;
  assign o_indirect_pointer16 = {s_q.ptr_high, s_q.ptr_low};
  assign o_onchip_ext_ram_page_reg      = {4'h0, s_q.page};
  assign o_sfr_rdata          = s_q.sfr_rdata;
  assign o_mem_map            = s_q.mem_out;
  assign o_prg_map            = s_q.prg_out;

endmodule
`default_nettype wire

// ==== bench/swdm_core_chk_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Status word and map checker
// ****************************************
module swdm_core_chk
(
  input wire logic                    i_sys_clk,
  input wire logic                    i_rst,
  input wire swdm_pkg::swdm_alu_req_t i_alu,
  input wire logic [7:0]              i_accum,
  input wire swdm_pkg::swdm_sfr_req_t i_sfr,
  input wire swdm_pkg::swdm_mem_req_t i_mem,
  input wire logic [7:0]              i_index_val,
  input wire logic [7:0]              o_status_word,
  input wire logic [7:0]              o_stack_top_ptr,
  input wire swdm_pkg::swdm_mem_map_t o_mem_map
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // Raw sums as nets, so properties stay short
  logic [8:0]  add_sum;
  logic [4:0]  nib_sum;
  logic [15:0] prod;
  logic        sw_wr;
  assign add_sum = {1'b0, i_alu.opa} + {1'b0, i_alu.opb};
  assign nib_sum = {1'b0, i_alu.opa[3:0]} + {1'b0, i_alu.opb[3:0]};
  assign prod = 16'(i_alu.opa) * 16'(i_alu.opb);
  assign sw_wr = i_sfr.wr | i_sfr.bit_wr;
  sequence s_alu(logic [2:0] op);
    i_alu.valid && i_alu.op == op;
  endsequence
  sequence s_mem(logic [2:0] k);
    i_mem.valid && i_mem.kind == k && !sw_wr;
  endsequence
  property p_add;
    s_alu(swdm_pkg::SWDM_ALU_ADD) |=> o_status_word[7:6] == {$past(add_sum[8]), $past(nib_sum[4])};
  endproperty
  a_add: assert property (p_add) else $error("add flags wrong");
  property p_mul;
    s_alu(swdm_pkg::SWDM_ALU_MUL) |=> o_status_word[2] == ($past(prod) > 16'h00ff) && !o_status_word[7];
  endproperty
  a_mul: assert property (p_mul) else $error("mul overflow wrong");
  property p_div;
    s_alu(swdm_pkg::SWDM_ALU_DIV) |=> o_status_word[2] == ($past(i_alu.opb) == 8'h00);
  endproperty
  a_div: assert property (p_div) else $error("div overflow wrong");
  property p_user;
    i_alu.valid && !sw_wr |=> $stable(o_status_word[5:3]) && $stable(o_status_word[1]);
  endproperty
  a_user: assert property (p_user) else $error("user bits moved");
  property p_parity;
    !$past(i_rst) |-> o_status_word[0] == ^$past(i_accum);
  endproperty
  a_parity: assert property (p_parity) else $error("parity wrong");
  property p_push;
    s_mem(swdm_pkg::SWDM_ACC_PUSH) |=> o_mem_map.byte_addr == $past(o_stack_top_ptr) + 8'h01
      && o_stack_top_ptr == $past(o_stack_top_ptr) + 8'h01;
  endproperty
  a_push: assert property (p_push) else $error("push order wrong");
  property p_upper;
    s_mem(swdm_pkg::SWDM_ACC_INDIRECT) ##0 (i_mem.reg_num < 3'd2 && i_index_val[7] && i_mem.addr[7])
      |=> o_mem_map.target == swdm_pkg::SWDM_TGT_UPPER_RAM;
  endproperty
  a_upper: assert property (p_upper) else $error("indirect high wrong");
  property p_bank;
    s_mem(swdm_pkg::SWDM_ACC_BANKREG) |=> o_mem_map.byte_addr ==
      {3'b000, $past(o_status_word[4:3]), $past(i_mem.reg_num)};
  endproperty
  a_bank: assert property (p_bank) else $error("bank address wrong");
endmodule
bind swdm_core swdm_core_chk u_swdm_core_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_alu(i_alu),
  .i_accum(i_accum), .i_sfr(i_sfr), .i_mem(i_mem), .i_index_val(i_index_val),
  .o_status_word(o_status_word), .o_stack_top_ptr(o_stack_top_ptr), .o_mem_map(o_mem_map));
`default_nettype wire

// ==== bench/swdm_dp_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ****************************************
// Datapath accumulator stand-in
// ****************************************
module swdm_dp_model
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic       i_load,
  input  wire logic [7:0] i_value,
  output logic [7:0]      o_accum
);
  // Clears on reset, loads on command
  always_ff @(posedge i_sys_clk or posedge i_rst)
  begin
    if (i_rst)
      o_accum <= 8'h00;
    else if (i_load)
      o_accum <= i_value;
  end
endmodule
`default_nettype wire

// ==== bench/status_word_and_data_map_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
module status_word_and_data_map_tb_top;
  logic                    clk, rst, fen, ld, cy, ac, ov;
  logic [7:0]              ldv, acc, idx, st, sp, pg, rd, a, b;
  logic [15:0]             dp;
  logic [31:0]             seed;
  int                      err_count, checks_done;
  swdm_pkg::swdm_alu_req_t alu;
  swdm_pkg::swdm_sfr_req_t sfr;
  swdm_pkg::swdm_mem_req_t mem;
  swdm_pkg::swdm_prg_req_t prg;
  swdm_pkg::swdm_mem_map_t mm;
  swdm_pkg::swdm_prg_map_t pm;
  swdm_pkg::swdm_alu_op_t  op;
  swdm_pkg::swdm_target_t  t;
  swdm_dp_model u_swdm_dp_model (.i_sys_clk(clk), .i_rst(rst), .i_load(ld), .i_value(ldv), .o_accum(acc));
  swdm_core u_swdm_core (.i_sys_clk(clk), .i_rst(rst), .i_alu(alu), .i_accum(acc), .i_sfr(sfr),
    .i_flash_wr_en(fen), .i_mem(mem), .i_index_val(idx), .i_prg(prg), .o_status_word(st),
    .o_stack_top_ptr(sp), .o_indirect_pointer16(dp), .o_onchip_ext_ram_page_reg(pg), .o_sfr_rdata(rd),
    .o_mem_map(mm), .o_prg_map(pm));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Flags {carry, half, overflow}; carry-in only for the chained ops
  function automatic logic [2:0] flags(swdm_pkg::swdm_alu_op_t o, logic [7:0] x, y, logic ci, o0);
    logic [8:0] r;
    logic [4:0] n;
    logic       c;
    c = ci & (o != swdm_pkg::SWDM_ALU_ADD);
    r = (o == swdm_pkg::SWDM_ALU_SUBB) ? {1'b0, x} - {1'b0, y} - 9'(c) : {1'b0, x} + {1'b0, y} + 9'(c);
    n = (o == swdm_pkg::SWDM_ALU_SUBB) ? {1'b0, x[3:0]} - {1'b0, y[3:0]} - 5'(c) : {1'b0, x[3:0]} + {1'b0, y[3:0]} + 5'(c);
    case (o)
      swdm_pkg::SWDM_ALU_ADD, swdm_pkg::SWDM_ALU_ADDC: return {r[8], n[4], x[7] == y[7] && r[7] != x[7]};
      swdm_pkg::SWDM_ALU_SUBB: return {r[8], n[4], x[7] != y[7] && r[7] != x[7]};
      swdm_pkg::SWDM_ALU_MUL: return {2'b00, 16'(x) * 16'(y) > 16'h00ff};
      swdm_pkg::SWDM_ALU_DIV: return {2'b00, y == 8'h00};
      default: return {2'b00, o0};
    endcase
  endfunction
  task automatic chk(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic sfr_wr(input logic [7:0] ad, d);
    sfr = '{wr:1'b1, bit_wr:1'b0, addr:ad, bit_pos:3'd0, wdata:d};
    tick();
    sfr.wr = 1'b0;
  endtask
  task automatic memq(input swdm_pkg::swdm_acc_kind_t k, input logic [7:0] ad, input logic [2:0] r);
    mem = '{valid:1'b1, kind:k, addr:ad, reg_num:r};
    tick();
    mem.valid = 1'b0;
  endtask
  task automatic prgq(input swdm_pkg::swdm_prg_kind_t k, input logic w, input logic [15:0] ad);
    prg = '{valid:1'b1, kind:k, write:w, addr:ad, index_val:8'h56};
    tick();
    prg.valid = 1'b0;
  endtask
  task automatic complete_run();
    $display("checks=%0d errors=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************
  // Clock, watchdog, sequence
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    complete_run();
  end
  initial
  begin
    {rst, fen, ld, ldv, idx, alu, sfr, mem, prg} = '0;
    rst = 1'b1;
    err_count = 0;
    checks_done = 0;
    seed = 32'd22167;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({st, sp}, 16'h0007);
    chk(dp | 16'(pg), 16'h0000);
    memq(swdm_pkg::SWDM_ACC_PUSH, 8'h00, 3'd0);
    chk({mm.byte_addr, sp}, 16'h0808);
    memq(swdm_pkg::SWDM_ACC_POP, 8'h00, 3'd0);
    chk({mm.byte_addr, sp}, 16'h0807);
    sfr_wr(8'h81, 8'hfe);
    memq(swdm_pkg::SWDM_ACC_PUSH, 8'h00, 3'd0);
    chk({mm.byte_addr, sp}, 16'hffff);
    // Even accumulator: parity must read back zero
    {ld, ldv} = {1'b1, 8'h03};
    tick();
    ld = 1'b0;
    sfr_wr(8'hd0, 8'hff);
    chk(16'(st), 16'h00fe);
    sfr = '{wr:1'b0, bit_wr:1'b1, addr:8'hd0, bit_pos:3'd5, wdata:8'h00};
    tick();
    sfr.bit_wr = 1'b0;
    tick();
    chk(16'(rd), 16'h00de);
    for (int k = 0; k < 4; k++)
    begin
      sfr_wr(8'hd0, {3'b000, 2'(k), 3'b000});
      memq(swdm_pkg::SWDM_ACC_BANKREG, 8'h00, 3'd5);
      chk(16'(mm.byte_addr), 16'(k * 8 + 5));
    end
    // Random addresses through both modes; same value on index and address
    for (int k = 0; k < 8; k++)
    begin
      a = 8'(rnd());
      idx = a;
      memq(swdm_pkg::SWDM_ACC_DIRECT, a, 3'd0);
      t = a[7] ? swdm_pkg::SWDM_TGT_SPECIAL : swdm_pkg::SWDM_TGT_LOWER_RAM;
      chk(16'({t, a, mm.is_bit}), 16'({mm.target, mm.byte_addr, 1'b0}));
      memq(swdm_pkg::SWDM_ACC_INDIRECT, a, 3'(k % 3));
      t = (k % 3 == 2) ? swdm_pkg::SWDM_TGT_NONE : a[7] ? swdm_pkg::SWDM_TGT_UPPER_RAM : swdm_pkg::SWDM_TGT_LOWER_RAM;
      chk(16'(mm.target), 16'(t));
      b = (k == 0) ? 8'h00 : (k == 1) ? 8'h7f : {1'b0, a[6:0]};
      memq(swdm_pkg::SWDM_ACC_BIT, b, 3'd0);
      chk({mm.byte_addr, 4'h0, mm.is_bit, mm.bit_pos}, {8'h20 + 8'(b[6:3]), 5'h01, b[2:0]});
    end
    prgq(swdm_pkg::SWDM_PRG_CODE_READ, 1'b0, 16'hfbff);
    chk(16'({pm.target, pm.lock_byte}), 16'({swdm_pkg::SWDM_TGT_FLASH, 1'b1}));
    prgq(swdm_pkg::SWDM_PRG_CODE_READ, 1'b0, 16'hfc00);
    chk(16'(pm.target), 16'(swdm_pkg::SWDM_TGT_RESERVED));
    sfr_wr(8'h82, 8'h34);
    sfr_wr(8'h83, 8'h12);
    prgq(swdm_pkg::SWDM_PRG_EXT_PTR16, 1'b1, 16'h0000);
    chk(pm.addr ^ 16'(pm.target), 16'h1234 ^ 16'(swdm_pkg::SWDM_TGT_ONCHIP_EXT_RAM));
    fen = 1'b1;
    prgq(swdm_pkg::SWDM_PRG_EXT_PTR16, 1'b1, 16'h0000);
    chk(16'(pm.target), 16'(swdm_pkg::SWDM_TGT_FLASH));
    fen = 1'b0;
    sfr_wr(8'haa, 8'hff);
    sfr.addr = 8'h85;
    tick();
    chk({pg, rd}, 16'h0f00);
    prgq(swdm_pkg::SWDM_PRG_EXT_PAGED, 1'b0, 16'h0000);
    chk(pm.addr, 16'h0f56);
    // Every op first, then random ones; user bits and bank must hold
    sfr_wr(8'hd0, 8'h3a);
    {cy, ac, ov} = 3'b000;
    for (int k = 0; k < 40; k++)
    begin
      op = swdm_pkg::swdm_alu_op_t'(k < 6 ? 3'(k + 1) : 3'(rnd() % 6 + 1));
      a = (k == 0) ? 8'hff : (k == 3) ? 8'h10 : 8'(rnd());
      b = (k == 0) ? 8'h01 : (k == 3) ? 8'h10 : (k == 4) ? 8'h00 : 8'(rnd());
      {cy, ac, ov} = flags(op, a, b, cy, ov);
      ldv = 8'(rnd());
      alu = '{valid:1'b1, op:op, opa:a, opb:b};
      ld = 1'b1;
      tick();
      {alu.valid, ld} = 2'b00;
      tick();
      chk(16'(st), 16'({cy, ac, 3'b111, ov, 1'b1, ^ldv}));
    end
    complete_run();
  end
endmodule
`default_nettype wire
